// file: pfci_consts.vh
/*
 * Constants for the pseudo-fault countdown injector: register offsets,
 * field positions, reset values and the tick timing.
 * Assumes it is included by bare name from each design file.
 */
`ifndef PFCI_CONSTS_VH
`define PFCI_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define PFCI_CTL_OFS 16'h0808
`define PFCI_CDN_OFS 16'h0810
`define PFCI_REC_STRIDE 16'h0040

// ****************************************
// Control fields and countdown width
// ****************************************
`define PFCI_BIT_COUNTDOWN_ENABLE 31
`define PFCI_BIT_RESTART 30
`define PFCI_BIT_MV 12
`define PFCI_BIT_AV 11
`define PFCI_BIT_PN 10
`define PFCI_BIT_ER 9
`define PFCI_BIT_CI 8
`define PFCI_ENA_MSB 7
`define PFCI_CNT_W 32

// ****************************************
// Reset values
// ****************************************
`define PFCI_RST_CNT 32'h00000000
`define PFCI_RST_ENA 8'h00
`define PFCI_RST_BIT 1'h0

// ****************************************
// Timing
// ****************************************
`define PFCI_CLK_PERIOD_NS 20
`define PFCI_TICK_PERIOD_NS 1000
`define PFCI_TICK_DIV (`PFCI_TICK_PERIOD_NS / `PFCI_CLK_PERIOD_NS)

`endif

// file: pfci_tick_gen.v
/*
 * Prescaler that turns the block clock into a one-cycle tick.
 * Assumes run and restart are synchronous to clk.
 */
`timescale 1ns/100ps
`include "pfci_consts.vh"

module pfci_tick_gen #(
    parameter DIV = `PFCI_TICK_DIV,
    parameter W = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire run,
    input wire restart,
    // Tick out
    output reg tick_ff
);

    reg [W-1:0] cnt_ff;
    reg [W-1:0] nxt_cnt;
    reg nxt_tick;
    // Cut to the counter width on purpose; DIV must fit in W bits
    localparam integer LAST_I = DIV - 1;
    localparam [W-1:0] LAST = LAST_I[W-1:0];

    // ****************************************
    // Divider
    // ****************************************
    // Restart realigns the phase so a fresh load waits a full tick
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (!run || restart) begin
            nxt_cnt = {W{1'b0}};
        end else if (cnt_ff == LAST) begin
            nxt_cnt = {W{1'b0}};
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            cnt_ff <= {W{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

endmodule

// file: pfci_gen_counter.v
/*
 * Hidden error generation counter: loads, decrements on tick,
 * flags the arrival at zero and optionally reloads.
 * Assumes load, tick and run are synchronous to clk.
 */
`timescale 1ns/100ps
`include "pfci_consts.vh"

module pfci_gen_counter #(
    parameter W = `PFCI_CNT_W
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire load,
    input wire run,
    input wire tick,
    input wire restart,
    input wire [W-1:0] reload_val,
    // Event
    output reg zero_hit
);

    reg [W-1:0] cnt_ff;
    reg [W-1:0] nxt_cnt;
    localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

    // ****************************************
    // Count
    // ****************************************
    always @* begin
        nxt_cnt = cnt_ff;
        zero_hit = 1'b0;
        if (load) begin
            nxt_cnt = reload_val;
        end else if (run && tick && cnt_ff != {W{1'b0}}) begin
            if (cnt_ff == ONE) begin
                zero_hit = 1'b1;
                if (restart) begin
                    nxt_cnt = reload_val;
                end else begin
                    nxt_cnt = {W{1'b0}};
                end
            end else begin
                nxt_cnt = cnt_ff - ONE;
            end
        end
    end

    // Not touched by the recovery reset; it only drives zero_hit
    always @(posedge clk) begin
        if (rst) begin
            cnt_ff <= `PFCI_RST_CNT;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

// file: pfci_injector.v
/*
 * Pseudo-fault countdown injector for the first record of one error
 * node: control and countdown registers on a memory-mapped port and a
 * selected-record system register port, prescaler, hidden counter,
 * and the injection request with the syndrome values to record.
 * A small state machine follows the hidden counter so the request and
 * the recorded values come from one registered decision per arrival
 * at zero; the counter value itself never leaves the counter module.
 * Assumes both access ports are synchronous to clk, that each request
 * is a single-cycle strobe, and that the error record logic samples
 * the injection outputs when inj_req_ff is high.
 */
//
// Contract
// - Writing one to countdown enable loads reload value into counter.
// - At zero with restart set, reload counter and keep counting.
// - While enabled and nonzero, decrement by one per tick.
// - At zero, request an injected error of the enabled types.
// - Reload value undefined after cold reset, kept over recovery reset.
// - Live counter value is never readable.
// - Bit 31 is countdown enable; zero disables counting.
// - Countdown enable clears on cold reset, kept over recovery reset.
// - Bit 30 restart; zero stops counter at zero without reload.
// - Bit 12 gives syndrome-valid value recorded with injected error.
// - Bit 11 gives address-valid value recorded with injected error.
// - Bits 12 and 11 become undefined on recovery reset.
// - Always-set valid flags make their bit read one, ignore writes.
// - Bit 10 gives poison value; kept over recovery reset.
// - Bit 9 gives reported value; kept over recovery reset.
// - Reserved bits read zero in both registers.
// - Registers exist only in node's first record; elsewhere read zero.
// - Control register at 808 hex plus 64 times record index.
// - Bit 8 gives critical value recorded with injected error.
// - Injection state entered when counter decrements to zero.
`timescale 1ns/100ps
`include "pfci_consts.vh"

module pfci_injector #(
    parameter [15:0] FIRST_REC = 16'h0000,
    parameter TICK_DIV = `PFCI_TICK_DIV,
    parameter MV_ALWAYS = 0,
    parameter AV_ALWAYS = 0
) (
    // Clock and resets
    input wire clk,
    input wire rst,
    input wire er_rst,
    // Memory-mapped access
    input wire [15:0] mm_addr,
    input wire mm_wr,
    input wire mm_rd,
    input wire [63:0] mm_wdata,
    output reg [63:0] mm_rdata_ff,
    output reg mm_rvalid_ff,
    // Selected-record system register access
    input wire [15:0] record_select_field,
    input wire sys_is_cdn,
    input wire sys_wr,
    input wire sys_rd,
    input wire [63:0] sys_wdata,
    output reg [63:0] sys_rdata_ff,
    output reg sys_rvalid_ff,
    // Injection toward the error record
    output reg inj_req_ff,
    output reg [7:0] inj_err_ena_ff,
    output reg inj_mv_ff,
    output reg inj_av_ff,
    output reg inj_pn_ff,
    output reg inj_er_ff,
    output reg inj_ci_ff
);

    // ****************************************
    // Decode
    // ****************************************
    localparam [15:0] CTL_ADDR = `PFCI_CTL_OFS +
        `PFCI_REC_STRIDE * FIRST_REC;
    localparam [15:0] CDN_ADDR = `PFCI_CDN_OFS +
        `PFCI_REC_STRIDE * FIRST_REC;

    // Register state
    reg [`PFCI_CNT_W-1:0] countdown_reload_value_ff;
    reg countdown_enable_ff;
    reg restart_ff;
    reg syndrome_valid_inject_ff;
    reg address_valid_inject_ff;
    reg poison_inject_ff;
    reg reported_flag_inject_ff;
    reg critical_flag_inject_ff;
    reg [7:0] err_ena_ff;

    // Access decode
    reg mm_ctl_hit;
    reg mm_cdn_hit;
    reg sys_hit;
    reg wr_ctl;
    reg wr_cdn;
    reg [63:0] wdata;
    reg [63:0] ctl_rd;
    reg [63:0] cdn_rd;
    reg [63:0] nxt_mm_rdata;
    reg [63:0] nxt_sys_rdata;

    // Counter links
    wire load;
    wire tick;
    wire zero_hit;

    always @* begin
        mm_ctl_hit = (mm_addr == CTL_ADDR);
        mm_cdn_hit = (mm_addr == CDN_ADDR);
        sys_hit = (record_select_field == FIRST_REC);
        wr_ctl = 1'b0;
        wr_cdn = 1'b0;
        wdata = mm_wdata;
        // A memory-mapped write wins over a same-cycle system write
        if (mm_wr && (mm_ctl_hit || mm_cdn_hit)) begin
            wr_ctl = mm_ctl_hit;
            wr_cdn = mm_cdn_hit;
        end else if (sys_wr && sys_hit) begin
            wr_ctl = !sys_is_cdn;
            wr_cdn = sys_is_cdn;
            wdata = sys_wdata;
        end
    end

    // ****************************************
    // Read values
    // ****************************************
    always @* begin
        ctl_rd = 64'h0000000000000000;
        ctl_rd[`PFCI_BIT_COUNTDOWN_ENABLE] = countdown_enable_ff;
        ctl_rd[`PFCI_BIT_RESTART] = restart_ff;
        ctl_rd[`PFCI_BIT_MV] = (MV_ALWAYS != 0) ? 1'b1 :
            syndrome_valid_inject_ff;
        ctl_rd[`PFCI_BIT_AV] = (AV_ALWAYS != 0) ? 1'b1 :
            address_valid_inject_ff;
        ctl_rd[`PFCI_BIT_PN] = poison_inject_ff;
        ctl_rd[`PFCI_BIT_ER] = reported_flag_inject_ff;
        ctl_rd[`PFCI_BIT_CI] = critical_flag_inject_ff;
        ctl_rd[`PFCI_ENA_MSB:0] = err_ena_ff;
        // Only the stored reload value is visible, never the counter
        cdn_rd = {32'h00000000, countdown_reload_value_ff};
    end

    always @* begin
        nxt_mm_rdata = 64'h0000000000000000;
        if (mm_ctl_hit) begin
            nxt_mm_rdata = ctl_rd;
        end else if (mm_cdn_hit) begin
            nxt_mm_rdata = cdn_rd;
        end
        nxt_sys_rdata = 64'h0000000000000000;
        if (sys_hit && sys_is_cdn) begin
            nxt_sys_rdata = cdn_rd;
        end else if (sys_hit) begin
            nxt_sys_rdata = ctl_rd;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            mm_rdata_ff <= 64'h0000000000000000;
            mm_rvalid_ff <= 1'b0;
            sys_rdata_ff <= 64'h0000000000000000;
            sys_rvalid_ff <= 1'b0;
        end else begin
            mm_rvalid_ff <= mm_rd;
            sys_rvalid_ff <= sys_rd;
            if (mm_rd) begin
                mm_rdata_ff <= nxt_mm_rdata;
            end else begin
                mm_rdata_ff <= 64'h0000000000000000;
            end
            if (sys_rd) begin
                sys_rdata_ff <= nxt_sys_rdata;
            end else begin
                sys_rdata_ff <= 64'h0000000000000000;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Unknown-at-reset fields are given zero so simulation stays clean
    always @(posedge clk) begin
        if (rst) begin
            countdown_reload_value_ff <= `PFCI_RST_CNT;
            countdown_enable_ff <= `PFCI_RST_BIT;
            restart_ff <= `PFCI_RST_BIT;
            syndrome_valid_inject_ff <= `PFCI_RST_BIT;
            address_valid_inject_ff <= `PFCI_RST_BIT;
            poison_inject_ff <= `PFCI_RST_BIT;
            reported_flag_inject_ff <= `PFCI_RST_BIT;
            critical_flag_inject_ff <= `PFCI_RST_BIT;
            err_ena_ff <= `PFCI_RST_ENA;
        end else if (er_rst) begin
            // Everything else is preserved over a recovery reset
            syndrome_valid_inject_ff <= `PFCI_RST_BIT;
            address_valid_inject_ff <= `PFCI_RST_BIT;
        end else begin
            if (wr_cdn) begin
                countdown_reload_value_ff <= wdata[`PFCI_CNT_W-1:0];
            end
            if (wr_ctl) begin
                countdown_enable_ff <= wdata[`PFCI_BIT_COUNTDOWN_ENABLE];
                restart_ff <= wdata[`PFCI_BIT_RESTART];
                if (MV_ALWAYS == 0) begin
                    syndrome_valid_inject_ff <= wdata[`PFCI_BIT_MV];
                end
                if (AV_ALWAYS == 0) begin
                    address_valid_inject_ff <= wdata[`PFCI_BIT_AV];
                end
                poison_inject_ff <= wdata[`PFCI_BIT_PN];
                reported_flag_inject_ff <= wdata[`PFCI_BIT_ER];
                critical_flag_inject_ff <= wdata[`PFCI_BIT_CI];
                err_ena_ff <= wdata[`PFCI_ENA_MSB:0];
            end
        end
    end

    // ****************************************
    // Counting
    // ****************************************
    // Every write of one reloads, even when already enabled
    assign load = wr_ctl && wdata[`PFCI_BIT_COUNTDOWN_ENABLE] && !rst && !er_rst;

    pfci_tick_gen #(
        .DIV(TICK_DIV),
        .W(16)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .run(countdown_enable_ff),
        .restart(load),
        .tick_ff(tick)
    );

    pfci_gen_counter #(
        .W(`PFCI_CNT_W)
    ) u_cnt (
        .clk(clk),
        .rst(rst),
        .load(load),
        .run(countdown_enable_ff),
        .tick(tick),
        .restart(restart_ff),
        .reload_val(countdown_reload_value_ff),
        .zero_hit(zero_hit)
    );

    // ****************************************
    // Injection state
    // ****************************************
    // Armed covers both counting and stopped at zero: the counter value
    // stays hidden, so only the arrival at zero is tracked here
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_INJ = 2'h2;

    // State registers
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg inj_enter;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                // Enable only turns on through a load
                if (load) begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // Arrival at zero implies the enable was set
                if (zero_hit) begin
                    nxt_state = ST_INJ;
                end else if (!countdown_enable_ff && !load) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_INJ: begin
                // Back-to-back arrivals keep the state and repeat the request
                if (zero_hit) begin
                    nxt_state = ST_INJ;
                end else if (countdown_enable_ff || load) begin
                    nxt_state = ST_ARMED;
                end else begin
                    nxt_state = ST_OFF;
                end
            end
            default: begin
                // Unused code falls back to off
                nxt_state = ST_OFF;
            end
        endcase
        inj_enter = (nxt_state == ST_INJ);
    end

    // Kept over the recovery reset, like the counter it follows
    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Injection
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            inj_req_ff <= 1'b0;
            inj_err_ena_ff <= 8'h00;
            inj_mv_ff <= 1'b0;
            inj_av_ff <= 1'b0;
            inj_pn_ff <= 1'b0;
            inj_er_ff <= 1'b0;
            inj_ci_ff <= 1'b0;
        end else begin
            inj_req_ff <= inj_enter;
            if (inj_enter) begin
                inj_err_ena_ff <= err_ena_ff;
                inj_mv_ff <= ctl_rd[`PFCI_BIT_MV];
                inj_av_ff <= ctl_rd[`PFCI_BIT_AV];
                inj_pn_ff <= poison_inject_ff;
                inj_er_ff <= reported_flag_inject_ff;
                inj_ci_ff <= critical_flag_inject_ff;
            end
        end
    end

endmodule

// file: pfci_injector_chk.sv
/* Checker for pfci_injector: register answers and injection request.
   Assumes a bind to pfci_injector, one clock, sync active-high rst. */
`timescale 1ns/100ps
module pfci_injector_chk #(
    parameter [15:0] FIRST_REC = 16'h0000,
    parameter MV_ALWAYS = 0,
    parameter AV_ALWAYS = 0
) (
    // Clock and resets
    input wire clk,
    input wire rst,
    input wire er_rst,
    // Memory-mapped access
    input wire [15:0] mm_addr,
    input wire mm_wr,
    input wire mm_rd,
    input wire [63:0] mm_wdata,
    input logic [63:0] mm_rdata_ff,
    input logic mm_rvalid_ff,
    // System register access
    input wire [15:0] record_select_field,
    input wire sys_is_cdn,
    input wire sys_wr,
    input wire sys_rd,
    input wire [63:0] sys_wdata,
    input logic [63:0] sys_rdata_ff,
    input logic sys_rvalid_ff,
    // Injection
    input logic inj_req_ff,
    input logic [7:0] inj_err_ena_ff,
    input logic inj_mv_ff,
    input logic inj_av_ff,
    input logic inj_pn_ff,
    input logic inj_er_ff,
    input logic inj_ci_ff
);
    // ****************************************
    // Shadow of the enable bit
    // ****************************************
    localparam [15:0] CTL = 16'h0808 + 16'h0040 * FIRST_REC;
    localparam [15:0] COUNTDOWN_RELOAD_VALUE = CTL + 16'h0008;
    logic en_ff;
    wire mm_hit = mm_addr == CTL || mm_addr == COUNTDOWN_RELOAD_VALUE;
    wire own = record_select_field == FIRST_REC;
    wire sys_ctl = sys_wr && !sys_is_cdn && own && !(mm_wr && mm_hit);
    // Writes in a recovery reset cycle are dropped, so they are here too
    always_ff @(posedge clk) begin
        if (rst) en_ff <= 1'h0;
        else if (!er_rst && mm_wr && mm_addr == CTL) en_ff <= mm_wdata[31];
        else if (!er_rst && sys_ctl) en_ff <= sys_wdata[31];
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_LAT: assert property (mm_rd && mm_hit |=> mm_rvalid_ff)
        else $error("mapped read got no answer");
    AST_RV_IDLE: assert property (!mm_rd |=> !mm_rvalid_ff &&
        mm_rdata_ff == 64'h0) else $error("read data outside answer");
    AST_CTL_RSVD: assert property (mm_rd && mm_addr == CTL |=>
        mm_rdata_ff[63:32] == 32'h0 && mm_rdata_ff[29:13] == 17'h0)
        else $error("control reserved bits not zero");
    AST_CDN_RSVD: assert property (sys_rd && sys_is_cdn && own |=>
        sys_rdata_ff[63:32] == 32'h0) else $error("countdown upper not 0");
    AST_UNMAP: assert property (mm_rd && !mm_hit |=>
        mm_rdata_ff == 64'h0) else $error("unmapped read not zero");
    AST_INJ_PULSE: assert property (inj_req_ff |=> !inj_req_ff)
        else $error("injection request longer than one cycle");
    AST_FLAG_HOLD: assert property (!inj_req_ff && !$past(rst) |->
        $stable({inj_err_ena_ff, inj_mv_ff, inj_av_ff, inj_pn_ff,
        inj_er_ff, inj_ci_ff})) else $error("flags moved without request");
    AST_DIS_NO_INJ: assert property (!en_ff [*2] |=> !inj_req_ff)
        else $error("injection while disabled");
    AST_ERST_MV: assert property (er_rst ##1 (!mm_wr && !sys_wr) [*2]
        ##0 (mm_rd && mm_addr == CTL) |=> mm_rdata_ff[12:11] ==
        {MV_ALWAYS != 0, AV_ALWAYS != 0})
        else $error("syndrome bits kept over recovery reset");
    AST_SYS_LAT: assert property (sys_rd |=> sys_rvalid_ff)
        else $error("system read got no answer");
    AST_SYS_IDLE: assert property (!sys_rd |=> !sys_rvalid_ff &&
        sys_rdata_ff == 64'h0) else $error("system data outside answer");
    AST_RAO: assert property (mm_rd && mm_addr == CTL |=>
        (MV_ALWAYS == 0 || mm_rdata_ff[12]) &&
        (AV_ALWAYS == 0 || mm_rdata_ff[11]))
        else $error("always-set syndrome bit read as zero");
endmodule
bind pfci_injector pfci_injector_chk #(.FIRST_REC(FIRST_REC),
    .MV_ALWAYS(MV_ALWAYS), .AV_ALWAYS(AV_ALWAYS)) chk_inst (
    .clk, .rst, .er_rst, .mm_addr, .mm_wr, .mm_rd, .mm_wdata,
    .mm_rdata_ff, .mm_rvalid_ff, .record_select_field, .sys_is_cdn,
    .sys_wr, .sys_rd, .sys_wdata, .sys_rdata_ff, .sys_rvalid_ff,
    .inj_req_ff,
    .inj_err_ena_ff, .inj_mv_ff, .inj_av_ff, .inj_pn_ff, .inj_er_ff,
    .inj_ci_ff);

// file: pfci_injector_tb_top.sv
/* Testbench for pfci_injector: register access and countdown timing.
   Assumes the checker is bound in; tick divider shortened to 2. */
`timescale 1ns/100ps
module pfci_injector_tb_top;
    localparam int D = 2;
    localparam [15:0] CTL = 16'h0808;
    localparam [15:0] COUNTDOWN_RELOAD_VALUE = 16'h0810;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic er_rst = 1'b0;
    logic [15:0] mm_addr = 16'h0;
    logic mm_wr = 1'b0;
    logic mm_rd = 1'b0;
    logic [63:0] mm_wdata = 64'h0;
    logic [15:0] record_select_field = 16'h0;
    logic sys_is_cdn = 1'b0;
    logic sys_wr = 1'b0;
    logic sys_rd = 1'b0;
    logic [63:0] sys_wdata = 64'h0;
    wire [63:0] mm_rdata_ff, sys_rdata_ff;
    wire mm_rvalid_ff, sys_rvalid_ff, inj_req_ff;
    wire [7:0] inj_err_ena_ff;
    wire inj_mv_ff, inj_av_ff, inj_pn_ff, inj_er_ff, inj_ci_ff;
    wire [12:0] flags = {inj_err_ena_ff, inj_mv_ff, inj_av_ff, inj_pn_ff,
        inj_er_ff, inj_ci_ff};
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0 = 0;

    pfci_injector #(.TICK_DIV(D)) pfci_injector_inst (
        .clk(clk), .rst(rst), .er_rst(er_rst), .mm_addr(mm_addr),
        .mm_wr(mm_wr), .mm_rd(mm_rd), .mm_wdata(mm_wdata),
        .mm_rdata_ff(mm_rdata_ff), .mm_rvalid_ff(mm_rvalid_ff),
        .record_select_field(record_select_field),
        .sys_is_cdn(sys_is_cdn), .sys_wr(sys_wr), .sys_rd(sys_rd),
        .sys_wdata(sys_wdata), .sys_rdata_ff(sys_rdata_ff),
        .sys_rvalid_ff(sys_rvalid_ff), .inj_req_ff(inj_req_ff),
        .inj_err_ena_ff(inj_err_ena_ff), .inj_mv_ff(inj_mv_ff),
        .inj_av_ff(inj_av_ff), .inj_pn_ff(inj_pn_ff),
        .inj_er_ff(inj_er_ff), .inj_ci_ff(inj_ci_ff));

    // ****************************************
    // Clock and tasks
    // ****************************************
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Each access spends two edges, so no strobe is set twice at once
    task mm(input logic w, input logic [15:0] a, input logic [63:0] d);
        @(posedge clk);
        #1;
        mm_addr = a;
        mm_wdata = d;
        mm_wr = w;
        mm_rd = !w;
        @(posedge clk);
        #1;
        mm_wr = 1'b0;
        mm_rd = 1'b0;
        if (!w) chk(mm_rdata_ff, d);
    endtask
    task sy(input logic w, input logic c, input logic [63:0] d);
        @(posedge clk);
        #1;
        sys_is_cdn = c;
        sys_wdata = d;
        sys_wr = w;
        sys_rd = !w;
        @(posedge clk);
        #1;
        sys_wr = 1'b0;
        sys_rd = 1'b0;
        if (!w) chk(sys_rdata_ff, d);
    endtask
    task wait_inj(input int e);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (inj_req_ff !== 1'b1 && k < 300);
        if (k == 300) begin
            n_mismatch++;
            stop_test;
        end
        chk(64'(cyc - t0), 64'(e));
        t0 = cyc;
    endtask
    task no_inj(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk(inj_req_ff, 1'b0);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        mm(0, CTL, 64'h0);
        mm(0, COUNTDOWN_RELOAD_VALUE, 64'h0);
        mm(0, 16'h0848, 64'h0);
        record_select_field = 16'h0001;
        sy(1, 0, 64'h8000_0000);
        sy(0, 0, 64'h0);
        record_select_field = 16'h0000;
        mm(0, CTL, 64'h0);
        $display("test reset done");
        mm(1, CTL, 64'hffff_ffff_ffff_ffff);
        mm(0, CTL, 64'h0000_0000_c000_1fff);
        sy(1, 1, 64'hffff_ffff_ffff_ffff);
        sy(0, 1, 64'h0000_0000_ffff_ffff);
        mm(1, CTL, 64'h0);
        no_inj(4);
        $display("test reserved done");
        sy(1, 1, 64'h3);
        mm(1, CTL, 64'h8000_15a5);
        t0 = cyc;
        wait_inj(3 * D + 1);
        chk(flags, {8'ha5, 5'h15});
        no_inj(20);
        sy(0, 0, 64'h8000_15a5);
        $display("test single done");
        sy(1, 1, 64'h2);
        mm(1, CTL, 64'hc000_0a5a);
        t0 = cyc;
        wait_inj(2 * D + 1);
        wait_inj(2 * D);
        chk(flags, {8'h5a, 5'h0a});
        mm(1, CTL, 64'h4000_0000);
        no_inj(20);
        mm(1, CTL, 64'h8000_0000);
        t0 = cyc;
        wait_inj(2 * D + 1);
        $display("test restart done");
        sy(1, 1, 64'h14);
        mm(1, CTL, 64'h8000_1f33);
        t0 = cyc;
        er_rst = 1'b1;
        mm(1, COUNTDOWN_RELOAD_VALUE, 64'h5);
        er_rst = 1'b0;
        mm(0, CTL, 64'h8000_0733);
        mm(0, COUNTDOWN_RELOAD_VALUE, 64'h14);
        wait_inj(20 * D + 1);
        chk(flags, {8'h33, 5'h07});
        $display("test recovery done");
        stop_test;
    end
endmodule
